// file: tb/dio_ext.sv
// model: switches on the input pins and pulled-up loads on the outputs
`timescale 1ns/1ps
module dio_ext
(
    // switch closures, 1 = switch on
    input  wire logic [15:0] sw,
    output logic      [15:0] in_pin,
    // open-collector outputs and the level seen at the loads
    input  wire logic [15:0] out_pin_o,
    input  wire logic [15:0] out_pin_oe,
    output logic      [15:0] load_lvl
);
    // closed switch shorts the pin to common, open one floats high
    assign in_pin   = ~sw;
    assign load_lvl = (out_pin_oe & out_pin_o) | ~out_pin_oe;
endmodule

// file: tb/dio_port_checker.sv
// checker: port-level properties of the digital io port
`timescale 1ns/1ps
module dio_port_checker
(
    // clock and reset
    input wire logic                       clk,
    input wire logic                       rst,
    // register port
    input wire logic [dio_pkg::DIO_AW-1:0] addr,
    input wire logic [dio_pkg::DIO_DW-1:0] wdata,
    input wire logic                       wr,
    input wire logic                       rd,
    input wire logic [dio_pkg::DIO_DW-1:0] rdata,
    // pins and interrupt
    input wire logic                       irq,
    input wire logic [15:0]                in_pin,
    input wire logic [15:0]                out_pin_o,
    input wire logic [15:0]                out_pin_oe
);
    import dio_pkg::*;
    logic [7:0]  quiet, next_quiet;
    logic [15:0] in_q, mask_sh, next_mask;
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    // cycles since any input pin moved, saturating
    always_comb
    begin
        next_quiet = (in_pin != in_q) ? 8'h00 : quiet + 8'(quiet != 8'hFF);
        next_mask  = (wr && addr == DIO_REG_MASK) ? wdata[15:0] : mask_sh;
        if (rst)
        begin
            next_quiet = 8'h00;
            next_mask  = DIO_MASK_RST;
        end
    end
    always_ff @(posedge clk)
    begin
        in_q    <= in_pin;
        quiet   <= next_quiet;
        mask_sh <= next_mask;
    end
    // only valid while the filter setting stays at or below 253 cycles
    sequence stat_read;
        rd && addr == DIO_REG_STAT && quiet == 8'hFF;
    endsequence
    chk_oc_never_high: assert property (out_pin_o == 16'h0000)
        else $error("open-collector output drove high");
    chk_out_write: assert property (wr && addr == DIO_REG_OUT |=>
        out_pin_oe == $past(wdata[15:0])) else $error("output write lost");
    chk_out_hold: assert property (!(wr && addr == DIO_REG_OUT) |=>
        $stable(out_pin_oe)) else $error("output moved without write");
    chk_out_reset: assert property (disable iff (1'b0) rst |=>
        out_pin_oe == DIO_OUT_RST) else $error("output on after reset");
    chk_out_readback: assert property (rd && addr == DIO_REG_OUT |=>
        rdata[15:0] == out_pin_oe) else $error("output readback wrong");
    chk_in_negative: assert property (rd && addr == DIO_REG_IN &&
        quiet >= 8'h28 |=> rdata[15:0] == ~$past(in_pin))
        else $error("input data not inverted pin level");
    chk_mask_silent: assert property (mask_sh == 16'hFFFF &&
        $past(mask_sh) == 16'hFFFF |-> !irq) else $error("masked irq");
    chk_stat_clear: assert property (stat_read |-> ##2 !irq)
        else $error("irq stayed after status read");
endmodule

bind dio_port dio_port_checker chk (.clk(clk), .rst(rst), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .irq(irq),
    .in_pin(in_pin), .out_pin_o(out_pin_o), .out_pin_oe(out_pin_oe));

// file: tb/dio_port_tb.sv
// testbench: register-level tests of the digital io port
`timescale 1ns/1ps
module dio_port_tb;
    import dio_pkg::*;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic [3:0]  addr = 4'h0;
    logic [31:0] wdata = 32'h0;
    logic        wr = 1'b0;
    logic        rd = 1'b0;
    logic [15:0] sw = 16'h0000;
    logic [31:0] rdata;
    logic        irq;
    logic [15:0] in_pin, out_pin_o, out_pin_oe, load_lvl;
    int          error_cnt = 0;
    int          n_compared = 0;
    int          cyc = 0;
    always #2 clk = ~clk;
    dio_port dut (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata),
        .wr(wr), .rd(rd), .rdata(rdata), .irq(irq), .in_pin(in_pin),
        .out_pin_o(out_pin_o), .out_pin_oe(out_pin_oe));
    dio_ext ext (.sw(sw), .in_pin(in_pin), .out_pin_o(out_pin_o),
        .out_pin_oe(out_pin_oe), .load_lvl(load_lvl));
    ////////////////////////////////////////////////////////////////////////
    task automatic close_out();
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk);
        wr    <= 1'b1;
        addr  <= a;
        wdata <= {16'h0000, d};
        @(posedge clk);
        wr    <= 1'b0;
    endtask
    task automatic rd_reg(input logic [3:0] a, input logic [15:0] e);
        @(posedge clk);
        rd   <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd   <= 1'b0;
        #1 check(rdata, {16'h0000, e});
    endtask
    task automatic settle(input int n);
        repeat (n) @(posedge clk);
    endtask
    // hang guard, far above the roughly 1100 cycles the tests need
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            error_cnt++;
            close_out();
        end
    end
    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        settle(8);
        rst <= 1'b0;
        rd_reg(DIO_REG_OUT, DIO_OUT_RST);
        rd_reg(DIO_REG_IEN, DIO_ZERO16);
        rd_reg(DIO_REG_EDGE, DIO_ZERO16);
        rd_reg(DIO_REG_STAT, DIO_ZERO16);
        rd_reg(DIO_REG_MASK, DIO_MASK_RST);
        rd_reg(DIO_REG_FILT, 16'h0019);
        rd_reg(4'hF, 16'h0000);
        check(32'(load_lvl), 32'h0000FFFF);
        $display("reset test done");
        wr_reg(DIO_REG_OUT, 16'hA5C3);
        rd_reg(DIO_REG_OUT, 16'hA5C3);
        check(32'(load_lvl), 32'h00005A3C);
        $display("output test done");
        sw <= 16'h00FF;
        settle(45);
        rd_reg(DIO_REG_IN, 16'h00FF);
        wr_reg(DIO_REG_IN, 16'h1234);
        sw <= 16'h01FF;
        settle(5);
        sw <= 16'h00FF;
        settle(45);
        rd_reg(DIO_REG_IN, 16'h00FF);
        rd_reg(DIO_REG_STAT, DIO_ZERO16);
        $display("input test done");
        wr_reg(DIO_REG_FILT, 16'h0005);
        rd_reg(DIO_REG_FILT, 16'h0005);
        // shorter settle: a change well under the reset time now passes
        sw <= 16'h04FF;
        settle(12);
        rd_reg(DIO_REG_IN, 16'h04FF);
        $display("filter test done");
        wr_reg(DIO_REG_IEN, 16'h7FFE);
        wr_reg(DIO_REG_EDGE, 16'hFF00);
        wr_reg(DIO_REG_MASK, 16'h0000);
        rd_reg(DIO_REG_IEN, 16'h7FFE);
        rd_reg(DIO_REG_EDGE, 16'hFF00);
        sw <= 16'hFF00;
        settle(300);
        check(32'(irq), 32'h0);
        sw <= 16'h00FF;
        settle(300);
        check(32'(irq), 32'h1);
        rd_reg(DIO_REG_STAT, 16'h7FFE);
        rd_reg(DIO_REG_STAT, DIO_ZERO16);
        check(32'(irq), 32'h0);
        wr_reg(DIO_REG_EDGE, 16'h0000);
        // all masked while a pending bit is set
        wr_reg(DIO_REG_MASK, 16'hFFFF);
        sw <= 16'h02FF;
        settle(300);
        check(32'(irq), 32'h0);
        wr_reg(DIO_REG_MASK, 16'h0000);
        settle(3);
        check(32'(irq), 32'h1);
        rd_reg(DIO_REG_STAT, 16'h0200);
        $display("interrupt test done");
        rst <= 1'b1;
        settle(8);
        rst <= 1'b0;
        rd_reg(DIO_REG_OUT, DIO_OUT_RST);
        rd_reg(DIO_REG_FILT, 16'h0019);
        check(32'(load_lvl), 32'h0000FFFF);
        $display("second reset test done");
        close_out();
    end
endmodule

// file: verilog/dio_filter.sv
// file: per-bit stability filter rejecting noise and chatter
`timescale 1ns/1ps
module dio_filter
(
    // clock and reset
    input  wire logic                          clk,
    input  wire logic                          rst,
    // settle time in cycles, zero passes input straight
    input  wire logic [dio_pkg::DIO_CW-1:0]    settle,
    // data
    input  wire logic [dio_pkg::DIO_NCH-1:0]   d,
    output logic      [dio_pkg::DIO_NCH-1:0]   q
);
    import dio_pkg::*;

    logic [DIO_NCH-1:0] next_q;

    genvar g;
    generate
        for (g = 0; g < DIO_NCH; g = g + 1)
        begin : g_bit
            logic [DIO_CW-1:0] cnt;
            logic [DIO_CW-1:0] next_cnt;

            // a change must persist settle cycles before it is accepted
            always_comb
            begin
                next_cnt  = DIO_CNT_ZERO;
                next_q[g] = q[g];
                if (d[g] != q[g])
                begin
                    if (cnt + DIO_CNT_ONE >= settle)
                        next_q[g] = d[g];
                    else
                        next_cnt = cnt + DIO_CNT_ONE;
                end
            end

            always_ff @(posedge clk)
            begin
                if (rst)
                begin
                    cnt  <= DIO_CNT_ZERO;
                    q[g] <= 1'b1;
                end
                else
                begin
                    cnt  <= next_cnt;
                    q[g] <= next_q[g];
                end
            end
        end
    endgenerate
endmodule

// file: verilog/dio_pkg.sv
// package: constants, register map and filter timing for the digital io port
package dio_pkg;
    localparam int        DIO_NCH        = 16;
    localparam int        DIO_AW         = 4;
    localparam int        DIO_DW         = 32;
    // register word offsets
    localparam [3:0]      DIO_REG_IN     = 4'h0;
    localparam [3:0]      DIO_REG_OUT    = 4'h1;
    localparam [3:0]      DIO_REG_IEN    = 4'h2;
    localparam [3:0]      DIO_REG_EDGE   = 4'h3;
    localparam [3:0]      DIO_REG_STAT   = 4'h4;
    localparam [3:0]      DIO_REG_MASK   = 4'h5;
    localparam [3:0]      DIO_REG_FILT   = 4'h6;
    // reset values
    localparam [15:0]     DIO_OUT_RST    = 16'h0000;
    localparam [15:0]     DIO_ZERO16     = 16'h0000;
    localparam [15:0]     DIO_MASK_RST   = 16'hFFFF;
    localparam [31:0]     DIO_RD_UNMAP   = 32'h0000_0000;
    // filter: input must hold steady this long to be accepted
    localparam int        DIO_CLK_MHZ    = 250;
    localparam int        DIO_FILT_NS    = 100;
    localparam int        DIO_FILT_CYC   = (DIO_FILT_NS * DIO_CLK_MHZ) / 1000;
    localparam int        DIO_CW         = 8;
    localparam [7:0]      DIO_FILT_RST   = 8'(DIO_FILT_CYC);
    localparam [7:0]      DIO_CNT_ZERO   = 8'h00;
    localparam [7:0]      DIO_CNT_ONE    = 8'h01;
endpackage

// file: verilog/dio_port.sv
// file: sixteen-in sixteen-out digital port with edge interrupts
//
// The placing of the registers and the strobed register port were left to the implementer.
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
module dio_port
(
    // clock and reset
    input  wire logic                          clk,
    input  wire logic                          rst,
    // register port
    input  wire logic [dio_pkg::DIO_AW-1:0]    addr,
    input  wire logic [dio_pkg::DIO_DW-1:0]    wdata,
    input  wire logic                          wr,
    input  wire logic                          rd,
    output logic      [dio_pkg::DIO_DW-1:0]    rdata,
    // interrupt
    output logic                               irq,
    // input pins
    input  wire logic [dio_pkg::DIO_NCH-1:0]   in_pin,
    // open-collector output pins
    output logic      [dio_pkg::DIO_NCH-1:0]   out_pin_o,
    output logic      [dio_pkg::DIO_NCH-1:0]   out_pin_oe
);
    import dio_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // input path

    logic [DIO_NCH-1:0] in_sync;
    logic [DIO_NCH-1:0] in_filt;
    logic [DIO_CW-1:0]  filt_set;

    dio_sync u_sync
    (
        .clk (clk),
        .rst (rst),
        .d   (in_pin),
        .q   (in_sync)
    );

    dio_filter u_filt
    (
        .clk    (clk),
        .rst    (rst),
        .settle (filt_set),
        .d      (in_sync),
        .q      (in_filt)
    );

    // data view: low pin reads 1
    logic [DIO_NCH-1:0] in_data;
    assign in_data = ~in_filt;

    ////////////////////////////////////////////////////////////////////////////
    // registers

    logic [DIO_NCH-1:0] out_reg;
    logic [DIO_NCH-1:0] ien;
    logic [DIO_NCH-1:0] edge_sel;
    logic [DIO_NCH-1:0] stat;
    logic [DIO_NCH-1:0] mask;
    logic [DIO_NCH-1:0] in_prev;
    logic [DIO_NCH-1:0] next_out_reg;
    logic [DIO_NCH-1:0] next_ien;
    logic [DIO_NCH-1:0] next_edge_sel;
    logic [DIO_NCH-1:0] next_stat;
    logic [DIO_NCH-1:0] next_mask;
    logic [DIO_NCH-1:0] next_in_prev;
    logic [DIO_CW-1:0]  next_filt_set;
    logic [DIO_DW-1:0]  next_rdata;
    logic               next_irq;
    logic [DIO_NCH-1:0] rise_pin;
    logic [DIO_NCH-1:0] fall_pin;
    logic [DIO_NCH-1:0] evt;

    always_comb
    begin
        // edge_sel 1: pin low-to-high, 0: pin high-to-low
        rise_pin = in_filt & ~in_prev;
        fall_pin = ~in_filt & in_prev;
        evt      = ((edge_sel & rise_pin) | (~edge_sel & fall_pin))
                   & ien;

        next_out_reg  = out_reg;
        next_ien      = ien;
        next_edge_sel = edge_sel;
        next_mask     = mask;
        next_filt_set = filt_set;
        next_in_prev  = in_filt;
        next_stat     = stat;
        next_rdata    = DIO_RD_UNMAP;

        if (wr)
        begin
            if (addr == DIO_REG_OUT)
                next_out_reg = wdata[DIO_NCH-1:0];
            else if (addr == DIO_REG_IEN)
                next_ien = wdata[DIO_NCH-1:0];
            else if (addr == DIO_REG_EDGE)
                next_edge_sel = wdata[DIO_NCH-1:0];
            else if (addr == DIO_REG_MASK)
                next_mask = wdata[DIO_NCH-1:0];
            else if (addr == DIO_REG_FILT)
                next_filt_set = wdata[DIO_CW-1:0];
        end

        if (rd)
        begin
            if (addr == DIO_REG_IN)
                next_rdata = {DIO_ZERO16, in_data};
            else if (addr == DIO_REG_OUT)
                next_rdata = {DIO_ZERO16, out_reg};
            else if (addr == DIO_REG_IEN)
                next_rdata = {DIO_ZERO16, ien};
            else if (addr == DIO_REG_EDGE)
                next_rdata = {DIO_ZERO16, edge_sel};
            else if (addr == DIO_REG_STAT)
            begin
                next_rdata = {DIO_ZERO16, stat};
                next_stat  = DIO_ZERO16; // read clears
            end
            else if (addr == DIO_REG_MASK)
                next_rdata = {DIO_ZERO16, mask};
            else if (addr == DIO_REG_FILT)
                next_rdata = {24'h000000, filt_set};
        end

        // set wins over the read clear in the same cycle
        next_stat = next_stat | evt;
        // one level line for all sources
        next_irq  = |(next_stat & ~next_mask);
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            out_reg  <= DIO_OUT_RST;
            ien      <= DIO_ZERO16;
            edge_sel <= DIO_ZERO16;
            mask     <= DIO_MASK_RST;
            filt_set <= DIO_FILT_RST;
            in_prev  <= {DIO_NCH{1'b1}};
            stat     <= DIO_ZERO16;
            rdata    <= DIO_RD_UNMAP;
            irq      <= 1'b0;
        end
        else
        begin
            out_reg  <= next_out_reg;
            ien      <= next_ien;
            edge_sel <= next_edge_sel;
            mask     <= next_mask;
            filt_set <= next_filt_set;
            in_prev  <= next_in_prev;
            stat     <= next_stat;
            rdata    <= next_rdata;
            irq      <= next_irq;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // open-collector drive: only ever pulls low, pull-up is external

    logic [DIO_NCH-1:0] next_oe;

    always_comb
    begin
        next_oe = next_out_reg;
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            out_pin_oe <= DIO_OUT_RST;
            out_pin_o  <= DIO_ZERO16;
        end
        else
        begin
            out_pin_oe <= next_oe;
            out_pin_o  <= DIO_ZERO16;
        end
    end
endmodule

// file: verilog/dio_sync.sv
// file: two-flop synchroniser for the input pins
`timescale 1ns/1ps
module dio_sync
(
    // clock and reset
    input  wire logic                          clk,
    input  wire logic                          rst,
    // data
    input  wire logic [dio_pkg::DIO_NCH-1:0]   d,
    output logic      [dio_pkg::DIO_NCH-1:0]   q
);
    import dio_pkg::*;

    logic [DIO_NCH-1:0] meta;
    logic [DIO_NCH-1:0] next_meta;
    logic [DIO_NCH-1:0] next_q;

    always_comb
    begin
        next_meta = d;
        next_q    = meta;
    end

    // pins idle high when pulled up
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            meta <= {DIO_NCH{1'b1}};
            q    <= {DIO_NCH{1'b1}};
        end
        else
        begin
            meta <= next_meta;
            q    <= next_q;
        end
    end
endmodule
